// ---- verilog/twsc_core.sv ----
// Two-wire serial core with its receive FIFO
`timescale 1ns/100ps
module twsc_fifo #(
	parameter int W = twsc_pkg::FIFO_W, // Word width
	parameter int D = twsc_pkg::FIFO_D // Depth, power of two
) (
	input logic i_clock, // Clock
	input logic i_rst_n, // Sync reset, low
	input logic i_valid, // Word offered
	input logic [W-1:0] i_data, // Word in
	output logic o_ready, // Room left
	output logic o_valid, // Word waiting
	output logic [W-1:0] o_data, // Head word
	input logic i_ready // Reader takes
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW:0] wp_ff;
	logic [AW:0] rp_ff;
	logic wr;
	logic rd;

	// Full when pointers differ only in the wrap bit
	assign o_valid = wp_ff != rp_ff;
	assign o_ready = !((wp_ff[AW] != rp_ff[AW]) &&
		(wp_ff[AW-1:0] == rp_ff[AW-1:0]));
	assign o_data = mem[rp_ff[AW-1:0]];
	assign wr = i_valid & o_ready;
	assign rd = o_valid & i_ready;

	// Pointers
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			wp_ff <= '0;
			rp_ff <= '0;
		end else begin
			wp_ff <= wp_ff + {{AW{1'b0}}, wr};
			rp_ff <= rp_ff + {{AW{1'b0}}, rd};
		end
	end

	// Storage
	always_ff @(posedge i_clock) begin
		if (wr) begin
			mem[wp_ff[AW-1:0]] <= i_data;
		end
	end
endmodule

module twsc_core (
	input logic i_clock, // 100 MHz clock
	input logic i_rst_n, // Sync reset, low
	input logic i_enable, // Core enable
	input twsc_pkg::twsc_cmd_t i_cmd, // Start, stop, ack enable
	input logic i_flag_clr, // Write one to event flag
	input logic i_irq_en, // Event interrupt enable
	input logic i_gie, // Global interrupt enable
	input logic [7:0] i_bitrate, // Bit rate divisor
	input logic [1:0] i_prescale, // Prescaler select
	input logic [6:0] i_own_addr, // Own slave address
	input logic i_gc_en, // General call enable
	input logic i_wake_abort, // Other wake source fired
	input logic i_data_we, // Load data shift reg
	input logic [7:0] i_data, // Byte to send
	output logic [7:0] o_data, // Data shift reg
	output logic [7:0] o_status, // Status code
	output logic o_event_flag, // Event flag
	output logic o_irq, // Interrupt request
	output logic o_rx_valid, // Received byte ready
	output logic [7:0] o_rx_data, // Received byte
	input logic i_rx_ready, // Reader takes byte
	input logic i_scl, // SCL level
	output logic o_scl_out, // SCL out value
	output logic o_scl_oe, // SCL pulled low
	input logic i_sda, // SDA level
	output logic o_sda_out, // SDA out value
	output logic o_sda_oe // SDA pulled low
);
	twsc_pkg::twsc_state_t state_ff;
	twsc_pkg::twsc_role_t role_ff;
	twsc_pkg::twsc_role_t end_role;
	logic [3:0] bit_ff;
	logic [14:0] cnt_ff;
	logic [14:0] half;
	logic [7:0] shift_ff;
	logic [7:0] code_ff;
	logic [7:0] status_ff;
	logic [7:0] end_code;
	logic [7:0] rxd_ff;
	logic hi_ff, scl_oe_ff, sda_oe_ff, scl_q, sda_q;
	logic busy_ff, lost_ff, is_addr_ff, rs_ff;
	logic ack_en_ff, ack_rx_ff, ev_ff, flag_ff, push_ff;
	logic master, tx, addr_hit, gc_hit, go, clr_ok;
	logic fifo_rdy, rise, fall, start_det, stop_det;
	logic cnt_end, end_push;

	// Half bit period: base plus divisor scaled by 1, 4, 16, 64
	function automatic logic [14:0] half_cnt(
		input logic [7:0] b,
		input logic [1:0] p
	);
		logic [14:0] m;
		m = {7'h00, b} << {p, 1'b0};
		half_cnt = twsc_pkg::HALF_BASE + m;
	endfunction

	// Bus edges and conditions
	assign rise = i_scl & ~scl_q;
	assign fall = ~i_scl & scl_q;
	assign start_det = scl_q & i_scl & sda_q & ~i_sda;
	assign stop_det = scl_q & i_scl & ~sda_q & i_sda;
	assign half = half_cnt(i_bitrate, i_prescale);
	assign cnt_end = cnt_ff == half - 15'h0001;
	assign master = role_ff == twsc_pkg::R_MT ||
		role_ff == twsc_pkg::R_MR;
	assign tx = role_ff == twsc_pkg::R_MT ||
		role_ff == twsc_pkg::R_ST;
	// Own address never matches the general call value
	assign addr_hit = shift_ff[7:1] == i_own_addr &&
		i_own_addr != twsc_pkg::GC_ADDR;
	assign gc_hit = i_gc_en && !shift_ff[0] &&
		shift_ff[7:1] == twsc_pkg::GC_ADDR;
	// A full FIFO refuses the flag clear and stalls the bus
	assign clr_ok = i_flag_clr && fifo_rdy;
	assign go = clr_ok && i_enable;

	// Pin drivers: open drain, value always low
	assign o_scl_out = 1'b0;
	assign o_sda_out = 1'b0;
	assign o_scl_oe = scl_oe_ff;
	assign o_sda_oe = sda_oe_ff;
	assign o_data = shift_ff;
	assign o_status = status_ff;
	assign o_event_flag = flag_ff;
	assign o_irq = flag_ff & i_irq_en & i_gie;

	// Previous pin samples
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= i_scl;
			sda_q <= i_sda;
		end
	end

	// Bus busy between START and STOP
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			busy_ff <= 1'b0;
		end else if (start_det) begin
			busy_ff <= 1'b1;
		end else if (stop_det) begin
			busy_ff <= 1'b0;
		end
	end

	// Event flag and status; set wins over clear
	always_ff @(posedge i_clock) begin
		if (!i_rst_n || !i_enable || i_wake_abort) begin
			flag_ff <= 1'b0;
			status_ff <= twsc_pkg::ST_NO_INFO;
		end else begin
			if (ev_ff) begin
				flag_ff <= 1'b1;
			end else if (clr_ok) begin
				flag_ff <= 1'b0;
			end
			if (flag_ff && !clr_ok) begin
				status_ff <= code_ff;
			end else begin
				status_ff <= twsc_pkg::ST_NO_INFO;
			end
		end
	end

	// Outcome of a finished byte
	always_comb begin
		end_code = twsc_pkg::ST_NO_INFO;
		end_role = role_ff;
		end_push = 1'b0;
		if (lost_ff) begin
			end_code = twsc_pkg::ST_ARB_LOST;
			end_role = twsc_pkg::R_NONE;
		end else begin
			case (role_ff)
				twsc_pkg::R_MT: begin
					if (!is_addr_ff) begin
						end_code = ack_rx_ff ? twsc_pkg::ST_MT_DAT_ACK :
							twsc_pkg::ST_MT_DAT_NACK;
					end else if (shift_ff[0]) begin
						end_role = twsc_pkg::R_MR;
						end_code = ack_rx_ff ? twsc_pkg::ST_MR_SLA_ACK :
							twsc_pkg::ST_MR_SLA_NACK;
					end else begin
						end_code = ack_rx_ff ? twsc_pkg::ST_MT_SLA_ACK :
							twsc_pkg::ST_MT_SLA_NACK;
					end
				end
				twsc_pkg::R_MR: begin
					end_push = 1'b1;
					end_code = ack_en_ff ? twsc_pkg::ST_MR_DAT_ACK :
						twsc_pkg::ST_MR_DAT_NACK;
				end
				twsc_pkg::R_SR: begin
					end_push = 1'b1;
					end_code = ack_en_ff ? twsc_pkg::ST_SR_DAT_ACK :
						twsc_pkg::ST_SR_DAT_NACK;
				end
				twsc_pkg::R_ST: begin
					end_code = ack_rx_ff ? twsc_pkg::ST_ST_DAT_ACK :
						twsc_pkg::ST_ST_DAT_NACK;
				end
				twsc_pkg::R_LISTEN: begin
					if (sda_oe_ff) begin
						end_role = shift_ff[0] ? twsc_pkg::R_ST :
							twsc_pkg::R_SR;
						if (shift_ff[0]) begin
							end_code = twsc_pkg::ST_ST_SLA_ACK;
						end else if (gc_hit) begin
							end_code = twsc_pkg::ST_SR_GC_ACK;
						end else begin
							end_code = twsc_pkg::ST_SR_SLA_ACK;
						end
					end else begin
						end_role = twsc_pkg::R_NONE;
					end
				end
				default: begin
					end_role = twsc_pkg::R_NONE;
				end
			endcase
		end
	end

	// Bus engine: clock generation, shifting, conditions
	always_ff @(posedge i_clock) begin
		ev_ff <= 1'b0;
		push_ff <= 1'b0;
		if (!i_rst_n || !i_enable || i_wake_abort) begin
			state_ff <= twsc_pkg::S_IDLE;
			role_ff <= twsc_pkg::R_NONE;
			bit_ff <= 4'h0;
			cnt_ff <= 15'h0000;
			hi_ff <= 1'b0;
			scl_oe_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
			lost_ff <= 1'b0;
			is_addr_ff <= 1'b0;
			rs_ff <= 1'b0;
			ack_en_ff <= 1'b0;
			ack_rx_ff <= 1'b0;
			code_ff <= twsc_pkg::ST_NO_INFO;
			rxd_ff <= 8'h00;
			if (!i_rst_n) begin
				shift_ff <= twsc_pkg::SHIFT_RST;
			end
		end else begin
			if (i_data_we && (state_ff == twsc_pkg::S_HOLD ||
				state_ff == twsc_pkg::S_IDLE)) begin
				shift_ff <= i_data;
			end
			case (state_ff)
				twsc_pkg::S_IDLE: begin
					scl_oe_ff <= 1'b0;
					if (go && i_cmd.start) begin
						state_ff <= twsc_pkg::S_START;
						cnt_ff <= 15'h0000;
						rs_ff <= 1'b0;
					end else if (start_det) begin
						// Address watch runs regardless of CPU sleep
						state_ff <= twsc_pkg::S_BYTE;
						role_ff <= twsc_pkg::R_LISTEN;
						bit_ff <= 4'h0;
					end
				end
				twsc_pkg::S_START: begin
					sda_oe_ff <= 1'b0;
					scl_oe_ff <= 1'b0;
					if (i_scl && i_sda && (!busy_ff || rs_ff)) begin
						if (cnt_end) begin
							sda_oe_ff <= 1'b1;
							cnt_ff <= 15'h0000;
							state_ff <= twsc_pkg::S_START2;
						end else begin
							cnt_ff <= cnt_ff + 15'h0001;
						end
					end else begin
						cnt_ff <= 15'h0000;
					end
				end
				twsc_pkg::S_START2: begin
					if (cnt_end) begin
						scl_oe_ff <= 1'b1;
						role_ff <= twsc_pkg::R_MT;
						is_addr_ff <= 1'b1;
						lost_ff <= 1'b0;
						code_ff <= rs_ff ? twsc_pkg::ST_RSTART :
							twsc_pkg::ST_START;
						ev_ff <= 1'b1;
						state_ff <= twsc_pkg::S_HOLD;
					end else begin
						cnt_ff <= cnt_ff + 15'h0001;
					end
				end
				twsc_pkg::S_HOLD: begin
					scl_oe_ff <= 1'b1;
					if (flag_ff && go) begin
						ack_en_ff <= i_cmd.ack_en;
						cnt_ff <= 15'h0000;
						hi_ff <= 1'b0;
						bit_ff <= 4'h0;
						if (i_cmd.stop && master) begin
							state_ff <= twsc_pkg::S_STOP;
						end else if (i_cmd.start) begin
							state_ff <= twsc_pkg::S_START;
							rs_ff <= master;
						end else if (role_ff != twsc_pkg::R_NONE) begin
							state_ff <= twsc_pkg::S_BYTE;
							sda_oe_ff <= tx & ~shift_ff[7];
							scl_oe_ff <= master;
						end else begin
							state_ff <= twsc_pkg::S_IDLE;
							scl_oe_ff <= 1'b0;
						end
					end
				end
				twsc_pkg::S_BYTE: begin
					// Master clock; low phase counts, high waits for SCL
					if (master) begin
						if (!hi_ff) begin
							if (cnt_end) begin
								scl_oe_ff <= 1'b0;
								hi_ff <= 1'b1;
								cnt_ff <= 15'h0000;
							end else begin
								cnt_ff <= cnt_ff + 15'h0001;
							end
						end else if (i_scl) begin
							if (cnt_end) begin
								scl_oe_ff <= 1'b1;
								hi_ff <= 1'b0;
								cnt_ff <= 15'h0000;
							end else begin
								cnt_ff <= cnt_ff + 15'h0001;
							end
						end else begin
							cnt_ff <= 15'h0000;
						end
					end
					// Slave side follows bus edges only
					if (start_det || stop_det) begin
						if (bit_ff == 4'h0 && (role_ff == twsc_pkg::R_SR ||
							role_ff == twsc_pkg::R_ST)) begin
							code_ff <= twsc_pkg::ST_SR_STOP;
							role_ff <= start_det ? twsc_pkg::R_LISTEN :
								twsc_pkg::R_NONE;
							sda_oe_ff <= 1'b0;
							scl_oe_ff <= 1'b1;
							ev_ff <= 1'b1;
							state_ff <= twsc_pkg::S_HOLD;
						end else if (role_ff == twsc_pkg::R_LISTEN &&
							bit_ff == 4'h0) begin
							if (stop_det) begin
								state_ff <= twsc_pkg::S_IDLE;
								role_ff <= twsc_pkg::R_NONE;
							end
						end else begin
							code_ff <= twsc_pkg::ST_BUS_ERR;
							role_ff <= twsc_pkg::R_NONE;
							sda_oe_ff <= 1'b0;
							scl_oe_ff <= 1'b1;
							ev_ff <= 1'b1;
							state_ff <= twsc_pkg::S_HOLD;
						end
					end else if (rise) begin
						if (bit_ff == twsc_pkg::ACK_BIT) begin
							ack_rx_ff <= ~i_sda;
						end else begin
							shift_ff <= {shift_ff[6:0], i_sda};
							if (master && tx && !sda_oe_ff && !i_sda) begin
								lost_ff <= 1'b1;
								sda_oe_ff <= 1'b0;
							end
						end
					end else if (fall) begin
						if (bit_ff == twsc_pkg::ACK_BIT) begin
							bit_ff <= 4'h0;
							is_addr_ff <= 1'b0;
							// Loss is reported once, then forgotten
							lost_ff <= 1'b0;
							sda_oe_ff <= 1'b0;
							hi_ff <= 1'b0;
							cnt_ff <= 15'h0000;
							role_ff <= end_role;
							push_ff <= end_push;
							rxd_ff <= shift_ff;
							if (end_code == twsc_pkg::ST_NO_INFO) begin
								state_ff <= twsc_pkg::S_IDLE;
								scl_oe_ff <= 1'b0;
							end else begin
								code_ff <= end_code;
								ev_ff <= 1'b1;
								scl_oe_ff <= 1'b1;
								state_ff <= twsc_pkg::S_HOLD;
							end
						end else begin
							bit_ff <= bit_ff + 4'h1;
							if (bit_ff == 4'h7) begin
								// Drive acknowledge when receiving
								sda_oe_ff <= ((role_ff == twsc_pkg::R_MR ||
									role_ff == twsc_pkg::R_SR) && ack_en_ff) ||
									(role_ff == twsc_pkg::R_LISTEN &&
									i_cmd.ack_en && (addr_hit || gc_hit));
							end else begin
								sda_oe_ff <= tx & ~lost_ff & ~shift_ff[7];
							end
						end
					end
				end
				twsc_pkg::S_STOP: begin
					sda_oe_ff <= 1'b1;
					scl_oe_ff <= 1'b1;
					if (cnt_end) begin
						scl_oe_ff <= 1'b0;
						cnt_ff <= 15'h0000;
						state_ff <= twsc_pkg::S_STOP2;
					end else begin
						cnt_ff <= cnt_ff + 15'h0001;
					end
				end
				twsc_pkg::S_STOP2: begin
					if (!i_scl) begin
						cnt_ff <= 15'h0000;
					end else if (cnt_end) begin
						sda_oe_ff <= 1'b0;
						role_ff <= twsc_pkg::R_NONE;
						state_ff <= twsc_pkg::S_IDLE;
					end else begin
						cnt_ff <= cnt_ff + 15'h0001;
					end
				end
				default: begin
					state_ff <= twsc_pkg::S_IDLE;
				end
			endcase
		end
	end

	// Received bytes pass through the FIFO
	twsc_fifo #(
		.W(twsc_pkg::FIFO_W),
		.D(twsc_pkg::FIFO_D)
	) u_rx_fifo (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_valid(push_ff),
		.i_data(rxd_ff),
		.o_ready(fifo_rdy),
		.o_valid(o_rx_valid),
		.o_data(o_rx_data),
		.i_ready(i_rx_ready)
	);

	// Checks
	property p_status_idle;
		@(posedge i_clock) disable iff (!i_rst_n)
		!o_event_flag |-> o_status == twsc_pkg::ST_NO_INFO;
	endproperty
	a_status_idle: assert property (p_status_idle)
		else $error("status not idle code while flag clear");

	property p_status_load;
		@(posedge i_clock) disable iff (!i_rst_n)
		($rose(o_event_flag) && !i_flag_clr)
			|=> o_status == $past(code_ff);
	endproperty
	a_status_load: assert property (p_status_load)
		else $error("status not loaded one cycle after flag");

	property p_scl_hold;
		@(posedge i_clock) disable iff (!i_rst_n)
		o_event_flag |-> o_scl_oe;
	endproperty
	a_scl_hold: assert property (p_scl_hold)
		else $error("SCL released while flag set");

	property p_irq;
		@(posedge i_clock) disable iff (!i_rst_n)
		($rose(o_event_flag) && i_irq_en && i_gie) |-> o_irq;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt missing on enabled event");

	property p_no_op;
		@(posedge i_clock) disable iff (!i_rst_n)
		o_event_flag |-> state_ff == twsc_pkg::S_HOLD;
	endproperty
	a_no_op: assert property (p_no_op)
		else $error("bus operation while flag set");

	property p_go;
		@(posedge i_clock) disable iff (!i_rst_n)
		(o_event_flag && go && !i_wake_abort)
			|=> !o_event_flag && state_ff != twsc_pkg::S_HOLD;
	endproperty
	a_go: assert property (p_go)
		else $error("operation not started after clear");

	property p_stop_quiet;
		@(posedge i_clock) disable iff (!i_rst_n)
		(state_ff == twsc_pkg::S_STOP2 ##1 state_ff == twsc_pkg::S_IDLE)
			|-> !ev_ff ##1 !o_event_flag;
	endproperty
	a_stop_quiet: assert property (p_stop_quiet)
		else $error("flag set after stop");

	property p_reset;
		@(posedge i_clock) disable iff (!i_rst_n)
		$rose(i_rst_n) |-> !o_event_flag && !o_scl_oe && !o_sda_oe &&
			o_status == twsc_pkg::ST_NO_INFO;
	endproperty
	a_reset: assert property (p_reset)
		else $error("not idle after reset");

	property p_low_phase;
		@(posedge i_clock) disable iff (!i_rst_n)
		(state_ff == twsc_pkg::S_BYTE && master && $rose(o_scl_oe) &&
			!i_wake_abort) |-> o_scl_oe [*8];
	endproperty
	a_low_phase: assert property (p_low_phase)
		else $error("master SCL low phase too short");

	property p_arb;
		@(posedge i_clock) disable iff (!i_rst_n)
		(lost_ff && state_ff == twsc_pkg::S_BYTE) |-> !o_sda_oe;
	endproperty
	a_arb: assert property (p_arb)
		else $error("SDA driven after arbitration loss");
endmodule

// ---- common/twsc_pkg.sv ----
// Package: constants and types of the two-wire serial core
// Contract
// - Master SCL period is sixteen plus twice divisor times prescale clocks.
// - Slave timing ignores divisor and prescale; clock must be 16x SCL.
// - Master clock waits while a slave stretches SCL low.
// - An 8-bit shift register holds the next or last address/data byte.
// - Hidden acknowledge bit: control sets it on receive, status shows it on send.
// - START, REPEATED START and STOP are generated and detected, even asleep.
// - A transmitting master watches for arbitration loss and reports it.
// - Received address bytes are compared with the seven-bit own address.
// - With general call enabled, the general call address also counts as addressed.
// - General call address is all zeros; never an ordinary slave address.
// - Address acknowledge depends on the acknowledge-enable control bit.
// - Address comparison keeps running while the CPU sleeps.
// - Another wake source aborts the operation back to idle.
// - Events set the flag; status code loads one clock later.
// - Status reads the no-information code whenever the flag is clear.
// - SCL is held low while the flag is set.
// - Flag sets after start, address, lost arbitration, addressed, data, slave stop.
// - Flag sets on a bus error from a misplaced START or STOP.
// - Interrupt request needs flag, event enable and global enable.
// - Writing one clears the flag; the requested operation then starts at once. The core refuses the clear while the receive FIFO is full.
// - After an address or data byte, status shows the acknowledge received, or the one sent when receiving data.
// - No flag is set after a software requested STOP completes.
package twsc_pkg;
	// Half of the fixed sixteen clock part of a bit period
	localparam logic [14:0] HALF_BASE = 15'h0008;
	// Status codes
	localparam logic [7:0] ST_BUS_ERR = 8'h00;
	localparam logic [7:0] ST_START = 8'h08;
	localparam logic [7:0] ST_RSTART = 8'h10;
	localparam logic [7:0] ST_MT_SLA_ACK = 8'h18;
	localparam logic [7:0] ST_MT_SLA_NACK = 8'h20;
	localparam logic [7:0] ST_MT_DAT_ACK = 8'h28;
	localparam logic [7:0] ST_MT_DAT_NACK = 8'h30;
	localparam logic [7:0] ST_ARB_LOST = 8'h38;
	localparam logic [7:0] ST_MR_SLA_ACK = 8'h40;
	localparam logic [7:0] ST_MR_SLA_NACK = 8'h48;
	localparam logic [7:0] ST_MR_DAT_ACK = 8'h50;
	localparam logic [7:0] ST_MR_DAT_NACK = 8'h58;
	localparam logic [7:0] ST_SR_SLA_ACK = 8'h60;
	localparam logic [7:0] ST_SR_GC_ACK = 8'h70;
	localparam logic [7:0] ST_SR_DAT_ACK = 8'h80;
	localparam logic [7:0] ST_SR_DAT_NACK = 8'h88;
	localparam logic [7:0] ST_SR_STOP = 8'hA0;
	localparam logic [7:0] ST_ST_SLA_ACK = 8'hA8;
	localparam logic [7:0] ST_ST_DAT_ACK = 8'hB8;
	localparam logic [7:0] ST_ST_DAT_NACK = 8'hC0;
	localparam logic [7:0] ST_NO_INFO = 8'hF8;
	// Reset values and fixed sizes
	localparam logic [7:0] SHIFT_RST = 8'hFF;
	localparam logic [6:0] GC_ADDR = 7'h00;
	localparam logic [3:0] ACK_BIT = 4'h8;
	localparam int FIFO_W = 8;
	localparam int FIFO_D = 8;
	// Engine states, Gray along idle-start-start2-hold-byte-stop-stop2
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_START = 3'h1,
		S_START2 = 3'h3,
		S_HOLD = 3'h2,
		S_BYTE = 3'h6,
		S_STOP = 3'h7,
		S_STOP2 = 3'h5
	} twsc_state_t;
	// Bus role of the core
	typedef enum logic [2:0] {
		R_NONE = 3'h0,
		R_LISTEN = 3'h1,
		R_MT = 3'h3,
		R_MR = 3'h2,
		R_ST = 3'h6,
		R_SR = 3'h7
	} twsc_role_t;
	// Operation request sampled when the flag is cleared
	typedef struct packed {
		logic start;
		logic stop;
		logic ack_en;
	} twsc_cmd_t;
endpackage

// ---- test/twsc_slave_model.sv ----
// Bus slave model: acknowledges, stretches SCL and answers reads
`timescale 1ns/100ps
module twsc_slave_model (
	input wire logic i_clock, // Clock
	input wire logic i_scl, // SCL level
	input wire logic i_sda, // SDA level
	input wire logic i_nack, // Refuse bytes
	input wire logic i_stretch, // Hold SCL low after each fall
	input wire logic [7:0] i_tx_byte, // Byte returned on reads
	output logic o_scl_oe, // Pull SCL low
	output logic o_sda_oe, // Pull SDA low
	output logic [7:0] o_byte // Last byte seen
);
	logic scl_q = 1'b1;
	logic sda_q = 1'b1;
	logic first = 1'b0;
	logic rd = 1'b0;
	logic pull_scl = 1'b0;
	logic pull_sda = 1'b0;
	logic [7:0] seen = 8'h00;
	int cnt = 0;
	int hold = 0;
	assign o_scl_oe = pull_scl;
	assign o_sda_oe = pull_sda;
	assign o_byte = seen;
	// Bit count, acknowledge slot, read data and clock stretch
	always @(posedge i_clock) begin
		scl_q <= i_scl;
		sda_q <= i_sda;
		pull_scl <= hold > 0;
		if (hold > 0) begin
			hold <= hold - 1;
		end
		if (i_scl && scl_q && sda_q && !i_sda) begin
			// START: an address byte follows
			cnt <= 0;
			first <= 1'b1;
			rd <= 1'b0;
		end else if (i_scl && !scl_q) begin
			if (cnt < 8) begin
				seen <= {seen[6:0], i_sda};
			end
			if (cnt == 8 && i_sda) begin
				rd <= 1'b0; // Master refused, stop sending
			end
			cnt <= cnt + 1;
		end else if (!i_scl && scl_q) begin
			hold <= i_stretch ? 40 : 0;
			if (cnt == 9) begin
				cnt <= 0;
				first <= 1'b0;
				rd <= first ? seen[0] : rd;
				pull_sda <= (first ? seen[0] : rd) && !i_tx_byte[7];
			end else if (rd) begin
				pull_sda <= cnt < 8 && !i_tx_byte[7 - cnt];
			end else begin
				pull_sda <= cnt == 8 && !i_nack;
			end
		end
	end
endmodule

// ---- test/testbench.sv ----
// Testbench: master transmit, master receive and abort of the two-wire serial core
`timescale 1ns/100ps
module testbench;
	logic i_clock, i_rst_n, i_enable, i_flag_clr, i_irq_en, i_gie;
	logic i_wake_abort, i_data_we, i_nack, i_stretch;
	logic [7:0] i_data, o_data, o_status, o_rx_data, m_byte;
	twsc_pkg::twsc_cmd_t i_cmd;
	logic o_event_flag, o_irq, o_rx_valid, o_scl_out, o_scl_oe;
	logic o_sda_out, o_sda_oe, m_scl_oe, m_sda_oe, scl, sda;
	logic i_rx_ready, ack_cfg;
	localparam logic [7:0] RD_BYTE = 8'h96;
	int error_cnt = 0;
	int compares = 0;
	// Wired-AND bus with pull-ups
	assign scl = !(o_scl_oe || m_scl_oe);
	assign sda = !(o_sda_oe || m_sda_oe);
	twsc_core i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
		.i_enable(i_enable), .i_cmd(i_cmd), .i_flag_clr(i_flag_clr),
		.i_irq_en(i_irq_en), .i_gie(i_gie), .i_bitrate(8'h02),
		.i_prescale(2'h1), .i_own_addr(7'h2A), .i_gc_en(1'b0),
		.i_wake_abort(i_wake_abort), .i_data_we(i_data_we),
		.i_data(i_data), .o_data(o_data), .o_status(o_status),
		.o_event_flag(o_event_flag), .o_irq(o_irq),
		.o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data),
		.i_rx_ready(i_rx_ready), .i_scl(scl), .o_scl_out(o_scl_out),
		.o_scl_oe(o_scl_oe), .i_sda(sda), .o_sda_out(o_sda_out),
		.o_sda_oe(o_sda_oe));
	twsc_slave_model i_model (.i_clock(i_clock), .i_scl(scl),
		.i_sda(sda), .i_nack(i_nack), .i_stretch(i_stretch),
		.i_tx_byte(RD_BYTE), .o_scl_oe(m_scl_oe),
		.o_sda_oe(m_sda_oe), .o_byte(m_byte));
	// 100 MHz clock
	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end
	task automatic finish_test;
		if (error_cnt == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	task automatic idle_chk;
		chk("flag", {7'h00, o_event_flag}, 8'h00);
		chk("status", o_status, twsc_pkg::ST_NO_INFO);
		chk("pins", {6'h00, o_scl_oe, o_sda_oe}, 8'h00);
	endtask
	// Flag first, code one cycle later, SCL held meanwhile
	task automatic wait_flag(input logic [7:0] code);
		int k;
		k = 0;
		while (o_event_flag !== 1'b1 && k < 3000) begin
			step(1);
			k++;
		end
		chk("flag set", {7'h00, o_event_flag}, 8'h01);
		chk("status early", o_status, twsc_pkg::ST_NO_INFO);
		step(1);
		chk("status", o_status, code);
		chk("scl held", {7'h00, o_scl_oe}, 8'h01);
		chk("pin values", {6'h00, o_scl_out, o_sda_out}, 8'h00);
	endtask
	task automatic clear(input logic st, input logic sp);
		i_cmd = '{start: st, stop: sp, ack_en: ack_cfg};
		i_flag_clr = 1'b1;
		step(1);
		i_flag_clr = 1'b0;
		chk("cleared", {7'h00, o_event_flag}, 8'h00);
	endtask
	task automatic load(input logic [7:0] b);
		i_data = b;
		i_data_we = 1'b1;
		step(1);
		i_data_we = 1'b0;
		chk("shift reg", o_data, b);
	endtask
	task automatic send(input logic [7:0] b, input logic [7:0] code);
		load(b);
		clear(1'b0, 1'b0);
		wait_flag(code);
		chk("slave byte", m_byte, b);
	endtask
	task automatic wait_lvl(input logic v, output int n);
		n = 0;
		while (scl !== v && n < 2000) begin
			step(1);
			n++;
		end
	endtask
	// Full write: start, address, data with stretch, refused data, stop
	task automatic t_write;
		int k;
		clear(1'b1, 1'b0);
		wait_flag(twsc_pkg::ST_START);
		for (k = 0; k < 4; k++) begin
			i_irq_en = k[0];
			i_gie = k[1];
			step(1);
			chk("irq", {7'h00, o_irq}, {7'h00, k == 3});
		end
		send(8'hA4, twsc_pkg::ST_MT_SLA_ACK);
		i_stretch = 1'b1;
		send(8'h3C, twsc_pkg::ST_MT_DAT_ACK);
		i_stretch = 1'b0;
		i_nack = 1'b1;
		send(8'hC3, twsc_pkg::ST_MT_DAT_NACK);
		i_nack = 1'b0;
		clear(1'b0, 1'b1);
		step(300);
		idle_chk();
	endtask
	// Repeated start, then master read of one refused byte
	task automatic t_read;
		clear(1'b1, 1'b0);
		wait_flag(twsc_pkg::ST_START);
		send(8'hA4, twsc_pkg::ST_MT_SLA_ACK);
		clear(1'b1, 1'b0);
		wait_flag(twsc_pkg::ST_RSTART);
		send(8'hA5, twsc_pkg::ST_MR_SLA_ACK);
		ack_cfg = 1'b0;
		clear(1'b0, 1'b0);
		ack_cfg = 1'b1;
		wait_flag(twsc_pkg::ST_MR_DAT_NACK);
		chk("rx valid", {7'h00, o_rx_valid}, 8'h01);
		chk("rx byte", o_rx_data, RD_BYTE);
		chk("read reg", o_data, RD_BYTE);
		i_rx_ready = 1'b1;
		step(1);
		i_rx_ready = 1'b0;
		chk("rx drained", {7'h00, o_rx_valid}, 8'h00);
		clear(1'b0, 1'b1);
		step(300);
		idle_chk();
	endtask
	// Bit period, then abort from another wake source
	task automatic t_rate;
		int a, b;
		clear(1'b1, 1'b0);
		wait_flag(twsc_pkg::ST_START);
		load(8'h56);
		clear(1'b0, 1'b0);
		wait_lvl(1'b1, a);
		wait_lvl(1'b0, a);
		wait_lvl(1'b1, b);
		chk("period ok", {7'h00, a + b >= 32 && a + b <= 35}, 8'h01);
		wait_flag(twsc_pkg::ST_MT_SLA_ACK);
		i_wake_abort = 1'b1;
		step(1);
		i_wake_abort = 1'b0;
		step(1);
		idle_chk();
	endtask
	// Watchdog
	initial begin
		#500000;
		error_cnt++;
		finish_test();
	end
	initial begin
		i_rst_n = 1'b0;
		i_enable = 1'b1;
		i_flag_clr = 1'b0;
		i_irq_en = 1'b0;
		i_gie = 1'b0;
		i_wake_abort = 1'b0;
		i_data_we = 1'b0;
		i_data = 8'h00;
		i_nack = 1'b0;
		i_stretch = 1'b0;
		i_cmd = '{start: 1'b0, stop: 1'b0, ack_en: 1'b1};
		ack_cfg = 1'b1;
		i_rx_ready = 1'b0;
		step(12);
		i_rst_n = 1'b1;
		idle_chk();
		chk("shift reset", o_data, twsc_pkg::SHIFT_RST);
		t_write();
		t_read();
		t_rate();
		finish_test();
	end
endmodule
